/* File: pkg/ffp_link_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface ffp_link_if;
    logic fast_request_low;
    logic normal_request_low;
    logic reg_rd;
    logic reg_wr;
    logic [8:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic reg_ack;
    modport dev (
        input reg_rd, reg_wr, reg_addr, reg_wdata,
        output reg_rdata, reg_ack, fast_request_low, normal_request_low
    );
    modport host (
        output reg_rd, reg_wr, reg_addr, reg_wdata,
        input reg_rdata, reg_ack, fast_request_low, normal_request_low
    );
endinterface
`default_nettype wire

/* File: pkg/ffp_pkg.sv */
`default_nettype none
package ffp_pkg;
    localparam int FFP_NSRC = 32;
    localparam int FFP_STACK_DEPTH = 8;
    // Register offsets seen by the core
    localparam logic [8:0] FFP_SMR_BASE = 9'h000;
    localparam logic [8:0] FFP_SVR_BASE = 9'h080;
    localparam logic [8:0] FFP_IVR = 9'h100;
    localparam logic [8:0] FFP_FVR = 9'h104;
    localparam logic [8:0] FFP_ISR = 9'h108;
    localparam logic [8:0] FFP_IPR = 9'h10c;
    localparam logic [8:0] FFP_IMR = 9'h110;
    localparam logic [8:0] FFP_CISR = 9'h114;
    localparam logic [8:0] FFP_IECR = 9'h120;
    localparam logic [8:0] FFP_IDCR = 9'h124;
    localparam logic [8:0] FFP_ICCR = 9'h128;
    localparam logic [8:0] FFP_ISCR = 9'h12c;
    localparam logic [8:0] FFP_EOICR = 9'h130;
    localparam logic [8:0] FFP_SPU = 9'h134;
    localparam logic [8:0] FFP_DCR = 9'h138;
    localparam logic [8:0] FFP_FFER = 9'h140;
    localparam logic [8:0] FFP_FFDR = 9'h144;
    localparam logic [8:0] FFP_FFSR = 9'h148;
    localparam logic [8:0] FFP_WPMR = 9'h1e4;
    localparam logic [8:0] FFP_WPSR = 9'h1e8;
    // Field layout
    localparam int FFP_PRI_LSB = 0;
    localparam int FFP_TYPE_LSB = 5;
    localparam logic [6:0] FFP_SMR_MASK = 7'h67;
    localparam int FFP_DCR_GUARD = 0;
    localparam int FFP_DCR_MASK = 1;
    localparam int FFP_WPMR_LOCK = 0;
    localparam int FFP_WPSR_FLAG = 0;
    localparam int FFP_WPSR_SRC_LSB = 8;
    localparam logic [31:0] FFP_REG_RST = 32'h0000_0000;
    // Host-side Wishbone map
    localparam logic [4:0] FFP_H_CMD = 5'h00;
    localparam logic [4:0] FFP_H_WDATA = 5'h04;
    localparam logic [4:0] FFP_H_RDATA = 5'h08;
    localparam logic [4:0] FFP_H_CTRL = 5'h0c;
    localparam logic [4:0] FFP_H_STAT = 5'h10;
    localparam int FFP_CMD_WE_BIT = 31;
    typedef enum logic [1:0] {
        FFP_H_IDLE = 2'b01,
        FFP_H_WAIT = 2'b10
    } ffp_host_state_e;
endpackage
`default_nettype wire

/* File: rtl/ffp_core_host.sv */
`timescale 1ns/100ps
`default_nettype none
module ffp_core_host import ffp_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    ffp_link_if.host link,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [4:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out
);
    ffp_host_state_e state_reg;
    logic [8:0] addr_reg, cmd_addr_reg;
    logic [31:0] wdata_reg, rdata_reg, wb_dat_reg;
    logic rd_reg, wr_reg, cmd_pend_reg, cmd_we_reg, wb_ack_reg;
    logic [1:0] ctrl_reg;
    logic fiq_prev_reg, irq_prev_reg, fiq_req_reg, irq_req_reg, chain_reg;
    logic wb_acc, wb_wr, busy, fiq_fall, irq_fall, start_chain, start_fiq, start_irq, start_cmd, idle;
    logic [31:0] wb_rd_next;

    assign wb_acc = wb_cyc_in & wb_stb_in & ~wb_ack_reg;
    assign wb_wr = wb_acc & wb_we_in & (&wb_sel_in);
    assign idle = (state_reg == FFP_H_IDLE);
    assign busy = cmd_pend_reg | ~idle;
    assign fiq_fall = fiq_prev_reg & ~link.fast_request_low;
    assign irq_fall = irq_prev_reg & ~link.normal_request_low;
    assign start_chain = idle & chain_reg;
    assign start_fiq = idle & ~chain_reg & fiq_req_reg;
    assign start_irq = idle & ~chain_reg & ~fiq_req_reg & irq_req_reg;
    assign start_cmd = idle & ~chain_reg & ~fiq_req_reg & ~irq_req_reg & cmd_pend_reg;

    assign wb_rd_next = (wb_adr_in == FFP_H_CMD) ? {cmd_we_reg, 22'h0, cmd_addr_reg}
        : (wb_adr_in == FFP_H_WDATA) ? wdata_reg
        : (wb_adr_in == FFP_H_RDATA) ? rdata_reg
        : (wb_adr_in == FFP_H_CTRL) ? {30'h0, ctrl_reg}
        : (wb_adr_in == FFP_H_STAT) ? {29'h0, ~link.normal_request_low, ~link.fast_request_low, busy}
        : FFP_REG_RST;

    assign link.reg_rd = rd_reg;
    assign link.reg_wr = wr_reg;
    assign link.reg_addr = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign wb_dat_out = wb_dat_reg;
    assign wb_ack_out = wb_ack_reg;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            wb_ack_reg <= 1'b0;
            wb_dat_reg <= FFP_REG_RST;
            ctrl_reg <= 2'b00;
            cmd_addr_reg <= 9'h000;
            cmd_we_reg <= 1'b0;
        end else begin
            wb_ack_reg <= wb_acc;
            if (wb_acc && !wb_we_in) wb_dat_reg <= wb_rd_next;
            if (wb_wr && wb_adr_in == FFP_H_CTRL) ctrl_reg <= wb_dat_in[1:0];
            if (wb_wr && wb_adr_in == FFP_H_CMD && !busy) begin
                cmd_addr_reg <= wb_dat_in[8:0];
                cmd_we_reg <= wb_dat_in[FFP_CMD_WE_BIT];
            end
        end
    end

    // Auto service requests latch on falling request lines
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            fiq_prev_reg <= 1'b1;
            irq_prev_reg <= 1'b1;
            fiq_req_reg <= 1'b0;
            irq_req_reg <= 1'b0;
            cmd_pend_reg <= 1'b0;
            chain_reg <= 1'b0;
        end else begin
            fiq_prev_reg <= link.fast_request_low;
            irq_prev_reg <= link.normal_request_low;
            fiq_req_reg <= (fiq_fall & ctrl_reg[0]) | (fiq_req_reg & ~start_fiq);
            irq_req_reg <= (irq_fall & ctrl_reg[0]) | (irq_req_reg & ~start_irq);
            cmd_pend_reg <= (wb_wr & (wb_adr_in == FFP_H_CMD) & ~busy) | (cmd_pend_reg & ~start_cmd);
            chain_reg <= (start_irq & ctrl_reg[1]) | (chain_reg & ~start_chain);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            state_reg <= FFP_H_IDLE;
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            addr_reg <= 9'h000;
            wdata_reg <= FFP_REG_RST;
            rdata_reg <= FFP_REG_RST;
        end else begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            if (wb_wr && wb_adr_in == FFP_H_WDATA && !busy) wdata_reg <= wb_dat_in;
            case (state_reg)
                FFP_H_IDLE: begin
                    if (start_chain) begin
                        addr_reg <= FFP_IVR;
                        wr_reg <= 1'b1;
                        state_reg <= FFP_H_WAIT;
                    end else if (start_fiq) begin
                        addr_reg <= FFP_FVR;
                        rd_reg <= 1'b1;
                        state_reg <= FFP_H_WAIT;
                    end else if (start_irq) begin
                        addr_reg <= FFP_IVR;
                        rd_reg <= 1'b1;
                        state_reg <= FFP_H_WAIT;
                    end else if (start_cmd) begin
                        addr_reg <= cmd_addr_reg;
                        rd_reg <= ~cmd_we_reg;
                        wr_reg <= cmd_we_reg;
                        state_reg <= FFP_H_WAIT;
                    end
                end
                FFP_H_WAIT: begin
                    if (link.reg_ack) begin
                        if (!wr_reg) rdata_reg <= link.reg_rdata;
                        state_reg <= FFP_H_IDLE;
                    end
                end
                default: state_reg <= FFP_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ffp_ctrl_dev.sv */
// Function
// - Edge fast source cleared by fast vector read
// - Handler removes level fast source at origin
// - Fast exception loads PC from fast vector
// - Unvectored handler reads fast vector first
// - Force enable/disable commands update force state
// - Forced source skips normal request and priority
// - Forced active level or edge raises fast request
// - Forcing leaves source 0 pending bit alone
// - Fast vector reads source 0 vector always
// - Software clears forced edge sources by command
// - Normal vector read never clears forced source
// - Source 0 stays one fast contributor
// - Protect bit set enables protect mode
// - Protect read evaluates; write pushes and acknowledges
// - Protect mode updates context only on write
// - Lone or repeated protect reads change nothing
// - Service routine writes normal vector after read
// - Normal mode read does everything; write ignored
// - No pending source returns spurious vector
// - Global mask idles both lines, wake stays
// - Locked config writes rejected and recorded
// - Status read clears violation flag
// - Trigger type selects level/edge, and polarity for external sources only
`timescale 1ns/100ps
`default_nettype none
module ffp_ctrl_dev import ffp_pkg::*; #(
    parameter int STACK_DEPTH = FFP_STACK_DEPTH,
    parameter logic [FFP_NSRC-1:0] EXT_MASK = 32'h0000_0001
) (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    ffp_link_if.dev link,
    input wire logic [FFP_NSRC-1:0] src_in,
    output logic wake_out
);
    localparam int SPW = $clog2(STACK_DEPTH + 1);
    localparam logic [SPW-1:0] SP_FULL = SPW'(STACK_DEPTH);

    logic [FFP_NSRC-1:0] lvl, edg, is_edge, ipr, elig;
    logic [6:0] smr_reg [FFP_NSRC];
    logic [31:0] svr_reg [FFP_NSRC];
    logic [31:0] spu_reg, imr_reg, ffsr_reg, pend_reg, pend_set, pend_clr, rdata_reg, rdata_next;
    logic [1:0] dcr_reg;
    logic lock_on_reg, viol_flag_reg, ack_reg, fiq_n_reg, irq_n_reg, wake_reg;
    logic [15:0] wpsrc_reg;
    logic [4:0] isr_reg, ivr_src_reg, best_src, ack_src, idx;
    logic ivr_hit_reg, best_hit, ack_hit;
    logic [2:0] best_pri, cur_lvl, ack_pri;
    logic [2:0] stk_lvl [STACK_DEPTH];
    logic [4:0] stk_src [STACK_DEPTH];
    logic [SPW-1:0] sp_reg, sp_top, sp_below;
    logic [8:0] a;
    logic [31:0] d;
    logic rd, wr, smr_hit, svr_hit, cfg_wr, blocked, wr_ok, ivr_rd, fvr_rd, ivr_wr, eoi_wr, wpsr_rd;
    logic guard_on, mask_all, do_ack, push, pop, forcing_used, fiq_any;

    genvar g;
    generate
        for (g = 0; g < FFP_NSRC; g++) begin : gen_src
            ffp_src_detect u_det (
                .sys_clk_in(sys_clk_in),
                .sys_rst_in(sys_rst_in),
                .raw_in(src_in[g]),
                .trig_in(smr_reg[g][FFP_TYPE_LSB +: 2]),
                .ext_in(EXT_MASK[g]),
                .level_out(lvl[g]),
                .edge_out(edg[g])
            );
            assign is_edge[g] = smr_reg[g][FFP_TYPE_LSB];
            assign ipr[g] = is_edge[g] ? pend_reg[g] : lvl[g];
        end
    endgenerate

    // Access decode
    assign rd = link.reg_rd;
    assign wr = link.reg_wr;
    assign a = link.reg_addr;
    assign d = link.reg_wdata;
    assign idx = a[6:2];
    assign smr_hit = (a[8:7] == FFP_SMR_BASE[8:7]);
    assign svr_hit = (a[8:7] == FFP_SVR_BASE[8:7]);
    assign cfg_wr = wr & (smr_hit | svr_hit | (a == FFP_SPU) | (a == FFP_DCR));
    assign blocked = cfg_wr & lock_on_reg;
    assign wr_ok = wr & ~blocked;
    assign ivr_rd = rd & (a == FFP_IVR);
    assign fvr_rd = rd & (a == FFP_FVR);
    assign ivr_wr = wr & (a == FFP_IVR);
    assign eoi_wr = wr & (a == FFP_EOICR);
    assign wpsr_rd = rd & (a == FFP_WPSR);
    assign guard_on = dcr_reg[FFP_DCR_GUARD];
    assign mask_all = dcr_reg[FFP_DCR_MASK];

    // Priority evaluation over non-forced normal sources
    assign elig = ipr & imr_reg & ~ffsr_reg;
    assign sp_top = sp_reg - 1'b1;
    assign sp_below = sp_reg - 2'd2;
    assign cur_lvl = stk_lvl[sp_top[$clog2(STACK_DEPTH)-1:0]];

    always_comb begin
        best_hit = 1'b0;
        best_src = 5'h00;
        best_pri = 3'h0;
        for (int i = 1; i < FFP_NSRC; i++) begin
            if (elig[i] && sp_reg != SP_FULL
                && (sp_reg == '0 || smr_reg[i][FFP_PRI_LSB +: 3] > cur_lvl)
                && (!best_hit || smr_reg[i][FFP_PRI_LSB +: 3] > best_pri)) begin
                best_hit = 1'b1;
                best_src = 5'(i);
                best_pri = smr_reg[i][FFP_PRI_LSB +: 3];
            end
        end
    end

    // Push and acknowledge: on read in normal mode, on write in protect mode
    assign do_ack = guard_on ? ivr_wr : ivr_rd;
    assign ack_src = guard_on ? ivr_src_reg : best_src;
    assign ack_hit = guard_on ? ivr_hit_reg : best_hit;
    assign ack_pri = smr_reg[ack_src][FFP_PRI_LSB +: 3];
    assign push = do_ack & ack_hit & (sp_reg != SP_FULL);
    assign pop = eoi_wr & (sp_reg != '0);
    assign forcing_used = |ffsr_reg[FFP_NSRC-1:1];

    // Pending latches for edge sources; set wins over clear
    assign pend_set = (edg & is_edge) | ((wr_ok && a == FFP_ISCR) ? (d & is_edge) : '0);
    assign pend_clr = ((wr_ok && a == FFP_ICCR) ? d : '0)
        | ((push && !ffsr_reg[ack_src]) ? (32'h1 << ack_src) : '0)
        | ((fvr_rd && !forcing_used) ? 32'h1 : '0);

    assign fiq_any = (ipr[0] & imr_reg[0]) | (|(ipr & imr_reg & ffsr_reg));

    always_comb begin
        if (smr_hit) begin
            rdata_next = {25'h0, smr_reg[idx]};
        end else if (svr_hit) begin
            rdata_next = svr_reg[idx];
        end else if (a == FFP_IVR) begin
            rdata_next = best_hit ? svr_reg[best_src] : spu_reg;
        end else if (a == FFP_FVR) begin
            rdata_next = svr_reg[0];
        end else if (a == FFP_ISR) begin
            rdata_next = {27'h0, isr_reg};
        end else if (a == FFP_IPR) begin
            rdata_next = ipr;
        end else if (a == FFP_IMR) begin
            rdata_next = imr_reg;
        end else if (a == FFP_CISR) begin
            rdata_next = {30'h0, ~irq_n_reg, ~fiq_n_reg};
        end else if (a == FFP_SPU) begin
            rdata_next = spu_reg;
        end else if (a == FFP_DCR) begin
            rdata_next = {30'h0, dcr_reg};
        end else if (a == FFP_FFSR) begin
            rdata_next = ffsr_reg;
        end else if (a == FFP_WPMR) begin
            rdata_next = {31'h0, lock_on_reg};
        end else if (a == FFP_WPSR) begin
            rdata_next = {8'h0, wpsrc_reg, 7'h0, viol_flag_reg};
        end else begin
            rdata_next = FFP_REG_RST;
        end
    end

    assign link.reg_rdata = rdata_reg;
    assign link.reg_ack = ack_reg;
    assign link.fast_request_low = fiq_n_reg;
    assign link.normal_request_low = irq_n_reg;
    assign wake_out = wake_reg;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            for (int i = 0; i < FFP_NSRC; i++) begin
                smr_reg[i] <= 7'h00;
                svr_reg[i] <= FFP_REG_RST;
            end
        end else if (wr_ok && smr_hit) begin
            smr_reg[idx] <= d[6:0] & FFP_SMR_MASK;
        end else if (wr_ok && svr_hit) begin
            svr_reg[idx] <= d;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            spu_reg <= FFP_REG_RST;
            dcr_reg <= 2'b00;
            imr_reg <= FFP_REG_RST;
            ffsr_reg <= FFP_REG_RST;
            lock_on_reg <= 1'b0;
        end else if (wr_ok) begin
            if (a == FFP_SPU) spu_reg <= d;
            if (a == FFP_DCR) dcr_reg <= d[1:0];
            if (a == FFP_IECR) imr_reg <= imr_reg | d;
            if (a == FFP_IDCR) imr_reg <= imr_reg & ~d;
            if (a == FFP_FFER) ffsr_reg <= ffsr_reg | (d & 32'hffff_fffe);
            if (a == FFP_FFDR) ffsr_reg <= ffsr_reg & ~d;
            if (a == FFP_WPMR) lock_on_reg <= d[FFP_WPMR_LOCK];
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pend_reg <= FFP_REG_RST;
            viol_flag_reg <= 1'b0;
            wpsrc_reg <= 16'h0000;
        end else begin
            pend_reg <= pend_set | (pend_reg & ~pend_clr);
            viol_flag_reg <= blocked | (viol_flag_reg & ~wpsr_rd);
            if (blocked) wpsrc_reg <= {7'h00, a};
        end
    end

    // Memorize on every IVR read; stack moves only on push or pop
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ivr_src_reg <= 5'h00;
            ivr_hit_reg <= 1'b0;
            sp_reg <= '0;
            isr_reg <= 5'h00;
        end else begin
            if (ivr_rd) begin
                ivr_src_reg <= best_src;
                ivr_hit_reg <= best_hit;
            end
            if (push) begin
                stk_lvl[sp_reg[$clog2(STACK_DEPTH)-1:0]] <= ack_pri;
                stk_src[sp_reg[$clog2(STACK_DEPTH)-1:0]] <= ack_src;
                sp_reg <= sp_reg + 1'b1;
                isr_reg <= ack_src;
            end else if (pop) begin
                sp_reg <= sp_top;
                isr_reg <= (sp_reg > 1) ? stk_src[sp_below[$clog2(STACK_DEPTH)-1:0]] : 5'h00;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            ack_reg <= 1'b0;
            rdata_reg <= FFP_REG_RST;
            fiq_n_reg <= 1'b1;
            irq_n_reg <= 1'b1;
            wake_reg <= 1'b0;
        end else begin
            ack_reg <= rd | wr;
            if (rd) rdata_reg <= rdata_next;
            fiq_n_reg <= ~(fiq_any & ~mask_all);
            irq_n_reg <= ~(best_hit & ~mask_all);
            wake_reg <= fiq_any | best_hit;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/ffp_src_detect.sv */
`timescale 1ns/100ps
`default_nettype none
module ffp_src_detect (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic raw_in,
    input wire logic [1:0] trig_in,
    input wire logic ext_in,
    output logic level_out,
    output logic edge_out
);
    logic sync1_reg, sync2_reg, level_reg, prev_reg;
    logic active;

    // Codes 0 and 1 invert external pins only
    assign active = sync2_reg ^ (ext_in & ~trig_in[1]);
    assign level_out = level_reg;
    assign edge_out = level_reg & ~prev_reg;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            level_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
            level_reg <= active;
            prev_reg <= level_reg;
        end
    end
endmodule
`default_nettype wire

/* File: verif/fast_irq_forcing_protect_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module fast_irq_forcing_protect_tb import ffp_pkg::*; ();
    logic sys_clk_in, sys_rst_in, cyc, stb, we_q, ack, wake;
    logic [4:0] adr;
    logic [31:0] dat, dout, rd_q, src;
    int errors, num_checks, cycles;
    ffp_link_if link_i();
    ffp_ctrl_dev i_ffp_ctrl_dev (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link_i),
        .src_in(src), .wake_out(wake));
    ffp_core_host i_ffp_core_host (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .link(link_i),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we_q), .wb_adr_in(adr), .wb_sel_in(4'hf),
        .wb_dat_in(dat), .wb_dat_out(dout), .wb_ack_out(ack));
    ffp_link_checker i_ffp_link_checker (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .fast_request_low(link_i.fast_request_low), .normal_request_low(link_i.normal_request_low),
        .reg_rd(link_i.reg_rd), .reg_wr(link_i.reg_wr), .reg_addr(link_i.reg_addr),
        .reg_wdata(link_i.reg_wdata), .reg_rdata(link_i.reg_rdata), .reg_ack(link_i.reg_ack));
    initial begin
        sys_clk_in = 1'b0;
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    task automatic close_out();
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // Classic single Wishbone cycle
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we_q <= we;
        adr <= a;
        dat <= d;
        do begin
            @(posedge sys_clk_in);
        end while (ack !== 1'b1);
        rd_q = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk_in);
    endtask
    // One device register access through the host
    task automatic lk(input logic we, input logic [8:0] a, input logic [31:0] d);
        if (we) wb(1'b1, FFP_H_WDATA, d);
        wb(1'b1, FFP_H_CMD, {we, 22'h0, a});
        do begin
            wb(1'b0, FFP_H_STAT, 32'h0);
        end while (rd_q[0] !== 1'b0);
        if (!we) wb(1'b0, FFP_H_RDATA, 32'h0);
    endtask
    task automatic rc(input string nm, input logic [8:0] a, input logic [31:0] e);
        lk(1'b0, a, 32'h0);
        chk(nm, e, rd_q);
    endtask
    task automatic lines(input logic [1:0] e);
        chk("lines", {30'h0, e}, {30'h0, link_i.fast_request_low, link_i.normal_request_low});
    endtask
    task automatic pulse5();
        src[5] <= 1'b0;
        w(4);
        src[5] <= 1'b1;
        w(6);
    endtask
    initial begin
        sys_rst_in = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we_q = 1'b0;
        adr = 5'h00;
        dat = 32'h0;
        src = 32'h1;
        repeat (4) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        @(posedge sys_clk_in);
        lines(2'b11);
        lk(1'b1, FFP_SVR_BASE, 32'h0000_1c00);
        lk(1'b1, FFP_SVR_BASE + 9'h014, 32'h0000_5500);
        lk(1'b1, FFP_SPU, 32'h0000_0bad);
        lk(1'b1, FFP_IECR, 32'h0000_0021);
        lk(1'b1, FFP_SMR_BASE + 9'h014, 32'h0000_0023);
        rc("unmapped", 9'h118, 32'h0);
        for (int c = 0; c < 4; c++) begin
            src[0] <= ~c[1];
            lk(1'b1, FFP_SMR_BASE, {25'h0, c[1:0], 5'h00});
            w(6);
            lk(1'b1, FFP_ICCR, 32'h1);
            lines(2'b11);
            src[0] <= c[1];
            w(6);
            lines(2'b01);
            rc("fvr", FFP_FVR, 32'h0000_1c00);
            lines({c[0], 1'b1});
            src[0] <= ~c[1];
            w(6);
            lines(2'b11);
        end
        lk(1'b1, FFP_DCR, 32'h1);
        pulse5();
        lines(2'b10);
        rc("ivr debug_protect_bit", FFP_IVR, 32'h0000_5500);
        rc("isr debug_protect_bit", FFP_ISR, 32'h0);
        rc("ivr again", FFP_IVR, 32'h0000_5500);
        rc("isr again", FFP_ISR, 32'h0);
        lines(2'b10);
        lk(1'b1, FFP_IVR, 32'h0);
        rc("isr wr", FFP_ISR, 32'h5);
        lines(2'b11);
        lk(1'b1, FFP_EOICR, 32'h0);
        lk(1'b1, FFP_DCR, 32'h0);
        pulse5();
        rc("ivr norm", FFP_IVR, 32'h0000_5500);
        lines(2'b11);
        rc("isr norm", FFP_ISR, 32'h5);
        lk(1'b1, FFP_EOICR, 32'h0);
        pulse5();
        lines(2'b10);
        lk(1'b1, FFP_DCR, 32'h2);
        lines(2'b11);
        chk("wake", 32'h1, {31'h0, wake});
        lk(1'b1, FFP_DCR, 32'h0);
        lines(2'b10);
        rc("cisr", FFP_CISR, 32'h2);
        lk(1'b1, FFP_ICCR, 32'h20);
        lk(1'b1, FFP_WPMR, 32'h1);
        lk(1'b1, FFP_SPU, 32'h0000_0777);
        rc("spu", FFP_SPU, 32'h0000_0bad);
        rc("wpsr", FFP_WPSR, 32'h0001_3401);
        lk(1'b0, FFP_WPSR, 32'h0);
        chk("wpsr clr", 32'h0, {31'h0, rd_q[0]});
        lk(1'b1, FFP_WPMR, 32'h0);
        lk(1'b1, FFP_FFER, 32'h21);
        rc("ffsr on", FFP_FFSR, 32'h20);
        pulse5();
        lines(2'b01);
        rc("ipr", FFP_IPR, 32'h20);
        rc("fvr forced", FFP_FVR, 32'h0000_1c00);
        lines(2'b01);
        rc("ivr spur", FFP_IVR, 32'h0000_0bad);
        rc("ipr kept", FFP_IPR, 32'h20);
        lk(1'b1, FFP_ICCR, 32'h20);
        lines(2'b11);
        lk(1'b1, FFP_FFDR, 32'h20);
        rc("ffsr off", FFP_FFSR, 32'h0);
        // Host serves both lines by itself from here on
        wb(1'b1, FFP_H_CTRL, 32'h3);
        src[0] <= 1'b1;
        w(16);
        lines(2'b11);
        wb(1'b0, FFP_H_RDATA, 32'h0);
        chk("auto fvr", 32'h0000_1c00, rd_q);
        lk(1'b1, FFP_DCR, 32'h1);
        pulse5();
        w(10);
        lines(2'b11);
        rc("isr auto", FFP_ISR, 32'h5);
        close_out();
    end
endmodule
`default_nettype wire

/* File: verif/ffp_link_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module ffp_link_checker import ffp_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    input wire logic fast_request_low,
    input wire logic normal_request_low,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [8:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_ack
);
    logic lock_reg, mask_reg, viol_reg;
    logic [31:0] sv0_reg, spu_reg, frc_reg;
    logic [15:0] vsrc_reg;
    wire logic guard_w = reg_addr < 9'h100 || reg_addr == FFP_SPU || reg_addr == FFP_DCR;
    wire logic ok_w = reg_wr && !lock_reg;
    // Shadow of what the device should hold
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            lock_reg <= 1'b0;
            mask_reg <= 1'b0;
            viol_reg <= 1'b0;
            sv0_reg <= 32'h0;
            spu_reg <= 32'h0;
            frc_reg <= 32'h0;
            vsrc_reg <= 16'h0;
        end else begin
            if (reg_wr && reg_addr == FFP_WPMR) lock_reg <= reg_wdata[0];
            if (ok_w && reg_addr == FFP_DCR) mask_reg <= reg_wdata[1];
            if (ok_w && reg_addr == FFP_SVR_BASE) sv0_reg <= reg_wdata;
            if (ok_w && reg_addr == FFP_SPU) spu_reg <= reg_wdata;
            if (reg_wr && reg_addr == FFP_FFER) frc_reg <= frc_reg | {reg_wdata[31:1], 1'b0};
            if (reg_wr && reg_addr == FFP_FFDR) frc_reg <= frc_reg & ~reg_wdata;
            if (reg_rd && reg_addr == FFP_WPSR) viol_reg <= 1'b0;
            if (reg_wr && lock_reg && guard_w) begin
                viol_reg <= 1'b1;
                vsrc_reg <= {7'h00, reg_addr};
            end
        end
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack)
        else $error("strobe without ack next cycle");
    a_ack_pulse: assert property (reg_ack |=> !reg_ack)
        else $error("ack longer than one cycle");
    a_ack_cause: assert property (reg_ack |-> $past(reg_rd || reg_wr))
        else $error("ack without strobe");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    a_mask_lines: assert property (mask_reg && $past(mask_reg) |-> fast_request_low && normal_request_low)
        else $error("request line active while masked");
    a_fvr_vector: assert property (reg_rd && reg_addr == FFP_FVR |=> reg_rdata == sv0_reg)
        else $error("fast vector not source 0 vector");
    a_spu_value: assert property (reg_rd && reg_addr == FFP_SPU |=> reg_rdata == spu_reg)
        else $error("spurious vector readback wrong");
    a_force_state: assert property (reg_rd && reg_addr == FFP_FFSR |=> reg_rdata == frc_reg)
        else $error("force state wrong");
    a_viol_flag: assert property (reg_rd && reg_addr == FFP_WPSR |=>
        reg_rdata[0] == $past(viol_reg) && (!reg_rdata[0] || reg_rdata[23:8] == vsrc_reg))
        else $error("violation status wrong");
endmodule
`default_nettype wire
